// [hdl/pcc_pkg.sv]
// constants of the pressure command conditioning block
package pcc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int SAMPLE_MS = 1;
	localparam logic [31:0] MS_CYCLES = 32'(CLK_HZ / 1000);
	localparam logic [31:0] SAMPLE_CYCLES = 32'(CLK_HZ / 1000 * SAMPLE_MS);
	localparam int DW = 12;
	localparam int I_FULL_MA = 2600;
	localparam int BAUD_DEFAULT = 57600;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_ST = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_RAMP_UP = 8'h10;
	localparam logic [7:0] OFS_RAMP_DN = 8'h14;
	localparam logic [7:0] OFS_MAX = 8'h18;
	localparam logic [7:0] OFS_MIN = 8'h1c;
	localparam logic [7:0] OFS_TRIG = 8'h20;
	localparam logic [7:0] OFS_GAINS = 8'h24;
	localparam logic [7:0] OFS_PWM = 8'h28;
	localparam logic [7:0] OFS_DITHER = 8'h2c;
	localparam logic [7:0] OFS_NOM = 8'h30;
	localparam logic [7:0] OFS_EMERG = 8'h34;
	localparam logic [7:0] OFS_BAUD = 8'h38;
	localparam logic [7:0] OFS_OUT = 8'h3c;
	// control bit positions
	localparam int CTRL_EMERG_EN = 0;
	localparam int CTRL_CUR_SENSOR = 1;
	localparam int CTRL_LOOP_EN = 2;
	localparam int CTRL_FF_EN = 3;
	localparam int CTRL_LOAD_DEF = 4;
	// interrupt bit positions
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_SENSOR = 1;
	localparam int IRQ_EN_LOST = 2;
	localparam int IRQ_EMERG = 3;
	// reset values
	localparam logic [3:0] RST_CTRL = 4'h5;
	localparam logic [15:0] RST_RAMP = 16'h0064;
	localparam logic [11:0] RST_MAX = 12'hfff;
	localparam logic [11:0] RST_MIN = 12'h000;
	localparam logic [11:0] RST_TRIG = 12'h000;
	localparam logic [7:0] RST_KP = 8'h40;
	localparam logic [7:0] RST_KI = 8'h04;
	localparam logic [7:0] RST_KD = 8'h00;
	localparam logic [3:0] RST_FILT = 4'h2;
	localparam logic [15:0] RST_PWM_PER = 16'h2710;
	localparam logic [15:0] RST_DITH_AMP = 16'h0000;
	localparam logic [7:0] RST_DITH_PER = 8'h08;
	localparam logic [11:0] RST_NOM = 12'hfff;
	localparam logic [11:0] RST_EMERG = 12'h000;
	localparam logic [17:0] RST_BAUD = 18'(BAUD_DEFAULT);
endpackage

// [hdl/pcc_pwm.sv]
// pwm generator with square dither on the duty
module pcc_pwm #(
	parameter int PW = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// settings
	input wire logic [PW-1:0] period,
	input wire logic [PW-1:0] duty,
	input wire logic [PW-1:0] dith_amp,
	input wire logic [7:0] dith_per,
	// solenoid drive
	output logic pwm_out
);
	typedef struct packed {
		logic [PW-1:0] cnt;
		logic [7:0] dcnt;
		logic dsign;
		logic out;
	} pcc_pwm_state_t;
	pcc_pwm_state_t s_reg, s_next;
	logic [PW:0] eff;
	always_comb
	begin
		s_next = s_reg;
		if (s_reg.dsign)
			eff = {1'b0, duty} + {1'b0, dith_amp};
		else
			eff = (duty > dith_amp) ? {1'b0, duty - dith_amp} : '0;
		if (s_reg.cnt + 1'b1 >= period)
		begin
			s_next.cnt = '0;
			if (s_reg.dcnt + 1'b1 >= dith_per)
			begin
				s_next.dcnt = 8'h00;
				s_next.dsign = ~s_reg.dsign;
			end
			else
				s_next.dcnt = s_reg.dcnt + 1'b1;
		end
		else
			s_next.cnt = s_reg.cnt + 1'b1;
		s_next.out = (duty != '0) && ({1'b0, s_reg.cnt} < eff);
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	assign pwm_out = s_reg.out;
endmodule

// [hdl/pcc_ramp.sv]
// rate limiter with separate rise and fall times
module pcc_ramp #(
	parameter int W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// target and full-scale travel times in cycles
	input wire logic [W-1:0] target,
	input wire logic [31:0] up_cycles,
	input wire logic [31:0] dn_cycles,
	// ramped value
	output logic [W-1:0] value
);
	localparam logic [31:0] FULL = 32'((1 << W) - 1);
	typedef struct packed {
		logic [31:0] acc;
		logic [W-1:0] val;
	} pcc_ramp_state_t;
	pcc_ramp_state_t s_reg, s_next;
	logic [31:0] acc2;
	logic [31:0] lim;
	always_comb
	begin
		s_next = s_reg;
		acc2 = s_reg.acc + FULL;
		lim = (target > s_reg.val) ? up_cycles : dn_cycles;
		if (target == s_reg.val)
		begin
			s_next.acc = 32'h0000_0000;
		end
		else if (lim == 32'h0000_0000)
		begin
			s_next.val = target;
			s_next.acc = 32'h0000_0000;
		end
		else if (acc2 >= lim)
		begin
			s_next.acc = acc2 - lim;
			s_next.val = (target > s_reg.val) ? s_reg.val + 1'b1 : s_reg.val - 1'b1;
		end
		else
		begin
			s_next.acc = acc2;
		end
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	assign value = s_reg.val;
endmodule

// [hdl/pcc_top.sv]
// pressure command conditioning: ramp, pid, output shaping, emergency, pwm
// Functional notes
// - on sensor fault or lost enable, drive the configured emergency value
// - emergency value is reached through the programmed ramp, not a jump
// - emergency function can be disabled; then a failure never substitutes it
// - emergency value kept apart from the parameter set and its reloads
// - separate rise and fall ramp times in milliseconds
// - ramp time equals the full travel time after a reference step
// - output scaled to a configurable maximum and never above it
// - a minimum offset is added to non-zero demand for valve overlap
// - below the threshold output is zero, forming a dead zone at zero
// - pid with gains, noise filter on derivative, and direct feed-forward
// - pwm current drive with nominal current, dither, frequency, 2.6 A full scale
// - configuration link rate defaults to 57600 baud
// - closed loop active only while enable is high; power stage also active while the emergency value is driven
// - ready only while enabled and no error present
// - open current-loop sensor is flagged as an error
//
// Register access over APB and the placing of the registers were chosen for this implementation.
module pcc_top (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and converters
	input wire logic enable_pin,
	input wire logic sensor_open_pin,
	input wire logic [11:0] cmd_in,
	input wire logic [11:0] fb_in,
	// outputs
	output logic pwm_out,
	output logic ready_out,
	output logic irq
);
	typedef struct packed {
		logic [1:0] en_s;
		logic [1:0] open_s;
		logic [11:0] cmd_s1;
		logic [11:0] cmd_s2;
		logic [11:0] fb_s1;
		logic [11:0] fb_s2;
		logic [3:0] ctrl;
		logic [15:0] ramp_up;
		logic [15:0] ramp_dn;
		logic [11:0] max_out;
		logic [11:0] min_out;
		logic [11:0] trig;
		logic [7:0] kp;
		logic [7:0] ki;
		logic [7:0] kd;
		logic [3:0] filt;
		logic [15:0] pwm_per;
		logic [15:0] dith_amp;
		logic [7:0] dith_per;
		logic [11:0] nom;
		logic [11:0] emerg;
		logic [17:0] baud;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [31:0] tick_cnt;
		logic signed [19:0] integ;
		logic signed [12:0] efilt;
		logic signed [12:0] eprev;
		logic [11:0] u;
		logic [11:0] shaped;
		logic [11:0] cur;
		logic [15:0] duty;
		logic fault_d;
		logic sens_d;
		logic en_d;
		logic emerg_d;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic ready;
		logic irq;
	} pcc_top_state_t;
	pcc_top_state_t s_reg, s_next;
	logic enable_ok;
	logic sensor_err;
	logic fault;
	logic emerg_act;
	logic [11:0] target;
	logic [11:0] ramped;
	logic [31:0] up_cyc;
	logic [31:0] dn_cyc;
	logic tick;
	logic acc_wr;
	logic signed [12:0] err;
	logic signed [13:0] ediff;
	logic signed [12:0] efilt_n;
	logic signed [21:0] pterm;
	logic signed [21:0] iterm;
	logic signed [21:0] dterm;
	logic signed [20:0] integ_n;
	logic signed [23:0] sum;
	logic [11:0] span;
	logic [23:0] lin;
	logic [12:0] shp;
	logic [23:0] cur_p;
	logic [27:0] duty_p;
	logic [3:0] ev;
	logic [31:0] rd;
	logic hit;
	always_comb
	begin
		s_next = s_reg;
		// pin synchronisers
		s_next.en_s = {s_reg.en_s[0], enable_pin};
		s_next.open_s = {s_reg.open_s[0], sensor_open_pin};
		s_next.cmd_s1 = cmd_in;
		s_next.cmd_s2 = s_reg.cmd_s1;
		s_next.fb_s1 = fb_in;
		s_next.fb_s2 = s_reg.fb_s1;
		// failure detection
		enable_ok = s_reg.en_s[1];
		sensor_err = s_reg.ctrl[pcc_pkg::CTRL_CUR_SENSOR] & s_reg.open_s[1];
		fault = ~enable_ok | sensor_err;
		emerg_act = fault & s_reg.ctrl[pcc_pkg::CTRL_EMERG_EN];
		// ramp target: emergency value goes through the ramp too
		if (emerg_act)
			target = s_reg.emerg;
		else if (enable_ok)
			target = s_reg.cmd_s2;
		else
			target = 12'h000;
		up_cyc = 32'(s_reg.ramp_up) * pcc_pkg::MS_CYCLES;
		dn_cyc = 32'(s_reg.ramp_dn) * pcc_pkg::MS_CYCLES;
		// sample tick
		tick = (s_reg.tick_cnt + 32'h0000_0001 >= pcc_pkg::SAMPLE_CYCLES);
		s_next.tick_cnt = tick ? 32'h0000_0000 : s_reg.tick_cnt + 32'h0000_0001;
		// pid with filtered derivative and feed-forward
		err = $signed({1'b0, ramped}) - $signed({1'b0, s_reg.fb_s2});
		ediff = 14'(err) - 14'(s_reg.efilt);
		efilt_n = s_reg.efilt + 13'(ediff >>> s_reg.filt);
		pterm = 22'($signed({1'b0, s_reg.kp})) * 22'(err);
		iterm = 22'($signed({1'b0, s_reg.ki})) * 22'(err);
		dterm = 22'($signed({1'b0, s_reg.kd})) * 22'(14'(efilt_n) - 14'(s_reg.eprev));
		integ_n = 21'(s_reg.integ) + 21'(iterm >>> 8);
		if (integ_n > 21'sd262143)
			integ_n = 21'sd262143;
		else if (integ_n < -21'sd262143)
			integ_n = -21'sd262143;
		sum = 24'(pterm >>> 8) + 24'(integ_n >>> 8) + 24'(dterm >>> 8);
		if (s_reg.ctrl[pcc_pkg::CTRL_FF_EN])
			sum = sum + 24'($signed({1'b0, ramped}));
		if (tick)
		begin
			s_next.efilt = efilt_n;
			s_next.eprev = efilt_n;
			s_next.integ = 20'(integ_n);
			if (sum < 24'sd0)
				s_next.u = 12'h000;
			else if (sum > 24'sd4095)
				s_next.u = 12'hfff;
			else
				s_next.u = 12'(sum);
		end
		if (!s_reg.ctrl[pcc_pkg::CTRL_LOOP_EN] || emerg_act || !enable_ok)
		begin
			s_next.u = ramped;
			s_next.integ = 20'sd0;
			s_next.efilt = 13'sd0;
			s_next.eprev = 13'sd0;
		end
		// output shaping: threshold, minimum offset, maximum
		span = (s_reg.max_out > s_reg.min_out) ? s_reg.max_out - s_reg.min_out : 12'h000;
		lin = 24'(s_reg.u - s_reg.trig) * 24'(span);
		shp = 13'(s_reg.min_out) + 13'(lin[23:12]);
		if (s_reg.u == 12'h000 || s_reg.u < s_reg.trig)
			s_next.shaped = 12'h000;
		else if (shp > 13'(s_reg.max_out))
			s_next.shaped = s_reg.max_out;
		else
			s_next.shaped = 12'(shp);
		if (!enable_ok && !emerg_act)
			s_next.shaped = 12'h000;
		// current demand and pwm duty
		cur_p = 24'(s_reg.shaped) * 24'(s_reg.nom);
		s_next.cur = cur_p[23:12];
		duty_p = 28'(s_reg.cur) * 28'(s_reg.pwm_per);
		s_next.duty = duty_p[27:12];
		s_next.ready = enable_ok & ~sensor_err;
		// interrupt events
		ev = 4'h0;
		ev[pcc_pkg::IRQ_FAULT] = fault & ~s_reg.fault_d;
		ev[pcc_pkg::IRQ_SENSOR] = sensor_err & ~s_reg.sens_d;
		ev[pcc_pkg::IRQ_EN_LOST] = ~enable_ok & s_reg.en_d;
		ev[pcc_pkg::IRQ_EMERG] = emerg_act & ~s_reg.emerg_d;
		s_next.fault_d = fault;
		s_next.sens_d = sensor_err;
		s_next.en_d = enable_ok;
		s_next.emerg_d = emerg_act;
		// apb decode
		acc_wr = psel & penable & pwrite & s_reg.pready;
		hit = 1'b1;
		rd = 32'h0000_0000;
		unique case (paddr)
			pcc_pkg::OFS_CTRL: rd = 32'(s_reg.ctrl);
			pcc_pkg::OFS_STATUS: rd = 32'({emerg_act, sensor_err, fault, enable_ok, s_reg.ready});
			pcc_pkg::OFS_IRQ_ST: rd = 32'(s_reg.irq_st);
			pcc_pkg::OFS_IRQ_MASK: rd = 32'(s_reg.irq_mask);
			pcc_pkg::OFS_RAMP_UP: rd = 32'(s_reg.ramp_up);
			pcc_pkg::OFS_RAMP_DN: rd = 32'(s_reg.ramp_dn);
			pcc_pkg::OFS_MAX: rd = 32'(s_reg.max_out);
			pcc_pkg::OFS_MIN: rd = 32'(s_reg.min_out);
			pcc_pkg::OFS_TRIG: rd = 32'(s_reg.trig);
			pcc_pkg::OFS_GAINS: rd = {4'h0, s_reg.filt, s_reg.kd, s_reg.ki, s_reg.kp};
			pcc_pkg::OFS_PWM: rd = 32'(s_reg.pwm_per);
			pcc_pkg::OFS_DITHER: rd = {8'h00, s_reg.dith_per, s_reg.dith_amp};
			pcc_pkg::OFS_NOM: rd = 32'(s_reg.nom);
			pcc_pkg::OFS_EMERG: rd = 32'(s_reg.emerg);
			pcc_pkg::OFS_BAUD: rd = 32'(s_reg.baud);
			pcc_pkg::OFS_OUT: rd = {4'h0, s_reg.shaped, 4'h0, ramped};
			default: hit = 1'b0;
		endcase
		// response stands for the access cycle only
		s_next.pready = psel & ~penable;
		s_next.prdata = 32'h0000_0000;
		s_next.pslverr = 1'b0;
		if (psel && !penable)
		begin
			s_next.prdata = pwrite ? 32'h0000_0000 : rd;
			s_next.pslverr = ~hit;
		end
		if (acc_wr && hit)
		begin
			unique case (paddr)
				pcc_pkg::OFS_CTRL: s_next.ctrl = pwdata[3:0];
				pcc_pkg::OFS_IRQ_MASK: s_next.irq_mask = pwdata[3:0];
				pcc_pkg::OFS_RAMP_UP: s_next.ramp_up = pwdata[15:0];
				pcc_pkg::OFS_RAMP_DN: s_next.ramp_dn = pwdata[15:0];
				pcc_pkg::OFS_MAX: s_next.max_out = pwdata[11:0];
				pcc_pkg::OFS_MIN: s_next.min_out = pwdata[11:0];
				pcc_pkg::OFS_TRIG: s_next.trig = pwdata[11:0];
				pcc_pkg::OFS_GAINS:
				begin
					s_next.kp = pwdata[7:0];
					s_next.ki = pwdata[15:8];
					s_next.kd = pwdata[23:16];
					s_next.filt = pwdata[27:24];
				end
				pcc_pkg::OFS_PWM: s_next.pwm_per = pwdata[15:0];
				pcc_pkg::OFS_DITHER:
				begin
					s_next.dith_amp = pwdata[15:0];
					s_next.dith_per = pwdata[23:16];
				end
				pcc_pkg::OFS_NOM: s_next.nom = pwdata[11:0];
				pcc_pkg::OFS_EMERG: s_next.emerg = pwdata[11:0];
				pcc_pkg::OFS_BAUD: s_next.baud = pwdata[17:0];
				default: s_next.ctrl = s_reg.ctrl;
			endcase
			// parameter set reload leaves the emergency value alone
			if (paddr == pcc_pkg::OFS_CTRL && pwdata[pcc_pkg::CTRL_LOAD_DEF])
			begin
				s_next.ctrl = pcc_pkg::RST_CTRL;
				s_next.ramp_up = pcc_pkg::RST_RAMP;
				s_next.ramp_dn = pcc_pkg::RST_RAMP;
				s_next.max_out = pcc_pkg::RST_MAX;
				s_next.min_out = pcc_pkg::RST_MIN;
				s_next.trig = pcc_pkg::RST_TRIG;
				s_next.kp = pcc_pkg::RST_KP;
				s_next.ki = pcc_pkg::RST_KI;
				s_next.kd = pcc_pkg::RST_KD;
				s_next.filt = pcc_pkg::RST_FILT;
				s_next.pwm_per = pcc_pkg::RST_PWM_PER;
				s_next.dith_amp = pcc_pkg::RST_DITH_AMP;
				s_next.dith_per = pcc_pkg::RST_DITH_PER;
				s_next.nom = pcc_pkg::RST_NOM;
			end
		end
		// sticky status, set wins over write-one-clear
		if (acc_wr && paddr == pcc_pkg::OFS_IRQ_ST)
			s_next.irq_st = (s_reg.irq_st & ~pwdata[3:0]) | ev;
		else
			s_next.irq_st = s_reg.irq_st | ev;
		s_next.irq = |(s_next.irq_st & s_next.irq_mask);
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
			s_reg.ctrl <= pcc_pkg::RST_CTRL;
			s_reg.ramp_up <= pcc_pkg::RST_RAMP;
			s_reg.ramp_dn <= pcc_pkg::RST_RAMP;
			s_reg.max_out <= pcc_pkg::RST_MAX;
			s_reg.min_out <= pcc_pkg::RST_MIN;
			s_reg.trig <= pcc_pkg::RST_TRIG;
			s_reg.kp <= pcc_pkg::RST_KP;
			s_reg.ki <= pcc_pkg::RST_KI;
			s_reg.kd <= pcc_pkg::RST_KD;
			s_reg.filt <= pcc_pkg::RST_FILT;
			s_reg.pwm_per <= pcc_pkg::RST_PWM_PER;
			s_reg.dith_amp <= pcc_pkg::RST_DITH_AMP;
			s_reg.dith_per <= pcc_pkg::RST_DITH_PER;
			s_reg.nom <= pcc_pkg::RST_NOM;
			s_reg.emerg <= pcc_pkg::RST_EMERG;
			s_reg.baud <= pcc_pkg::RST_BAUD;
			// no false fault edge while the synchronisers fill
			s_reg.fault_d <= 1'b1;
			s_reg.emerg_d <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
	pcc_ramp #(
		.W(pcc_pkg::DW)
	) u_ramp (
		.clk(clk),
		.nrst(nrst),
		.target(target),
		.up_cycles(up_cyc),
		.dn_cycles(dn_cyc),
		.value(ramped)
	);
	pcc_pwm #(
		.PW(16)
	) u_pwm (
		.clk(clk),
		.nrst(nrst),
		.period(s_reg.pwm_per),
		.duty(s_reg.duty),
		.dith_amp(s_reg.dith_amp),
		.dith_per(s_reg.dith_per),
		.pwm_out(pwm_out)
	);
	// registered outputs
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign ready_out = s_reg.ready;
	assign irq = s_reg.irq;
endmodule

// [verification/pcc_top_checker.sv]
// port assertions for the pressure command block
module pcc_top_checker (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic enable_pin,
	input wire logic sensor_open_pin,
	input wire logic [11:0] cmd_in,
	input wire logic [11:0] fb_in,
	input wire logic pwm_out,
	input wire logic ready_out,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	chk_setup_gets_ready: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	chk_ready_has_setup: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("pslverr alone or with data");
	chk_disabled_not_ready: assert property ((!enable_pin) [*5] |-> !ready_out)
		else $error("ready while disabled");
	chk_ready_needs_enable: assert property ($rose(ready_out) |-> $past(enable_pin))
		else $error("ready rose without enable");
	chk_ready_drop_cause: assert property ($fell(ready_out) |-> $past(!enable_pin || sensor_open_pin, 3))
		else $error("ready fell with enable high and sensor closed");
	chk_irq_drop_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
		else $error("irq fell without write");
	cover property (pslverr);
	cover property ($fell(ready_out));
	cover property ($fell(irq));
endmodule

// [verification/pcc_valve_model.sv]
// solenoid and pressure sensor model
module pcc_valve_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// drive and test control
	input wire logic pwm_out,
	input wire logic open_req,
	// sensor side
	output logic [11:0] fb_in,
	output logic sensor_open_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// pressure follows the mean drive
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			fb_in <= 12'h000;
		else if (pwm_out && fb_in != 12'hfff)
			fb_in <= fb_in + 12'h001;
		else if (!pwm_out && fb_in != 12'h000)
			fb_in <= fb_in - 12'h001;
	end
	assign sensor_open_pin = open_req;
endmodule

// [verification/tb_top.sv]
// testbench for the pressure command block
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, x); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, enable_pin = 1, open_req = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic pready, pslverr, sensor_open_pin, pwm_out, ready_out, irq, e;
	logic [11:0] cmd_in = 0, fb_in;
	int mismatches = 0, compares = 0;
	int n1, n2;
	always #50 clk = ~clk;
	pcc_top pcc_top_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enable_pin(enable_pin), .sensor_open_pin(sensor_open_pin),
		.cmd_in(cmd_in), .fb_in(fb_in), .pwm_out(pwm_out), .ready_out(ready_out), .irq(irq));
	pcc_valve_model pcc_valve_model_i (.clk(clk), .nrst(nrst), .pwm_out(pwm_out),
		.open_req(open_req), .fb_in(fb_in), .sensor_open_pin(sensor_open_pin));
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 16)
		begin
			mismatches++;
			end_sim;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(q, x)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// length of the next whole pwm pulse in cycles
	task automatic pulse(output int n);
		int k;
		n = 0;
		k = 0;
		while (pwm_out !== 1'b0 && k < 20000)
		begin
			@(posedge clk);
			k++;
		end
		while (pwm_out !== 1'b1 && k < 20000)
		begin
			@(posedge clk);
			k++;
		end
		while (pwm_out === 1'b1 && k < 20000)
		begin
			@(posedge clk);
			n++;
			k++;
		end
		if (k >= 20000)
		begin
			mismatches++;
			end_sim;
		end
	endtask
	// expected shaped output
	function automatic logic [11:0] shp(input logic [11:0] u, mx, mn, tg);
		logic [31:0] v;
		v = 32'(mn) + (((32'(u) - 32'(tg)) * (32'(mx) - 32'(mn))) >> 12);
		if (u == 12'h000 || u < tg)
			v = 32'h0000_0000;
		else if (v > 32'(mx))
			v = 32'(mx);
		return v[11:0];
	endfunction
	initial
	begin
		cyc(20);
		nrst <= 1'b1;
		@(posedge clk);
		rc(8'h00, 32'h0000_0005);
		rc(8'h10, 32'h0000_0064);
		rc(8'h18, 32'h0000_0fff);
		rc(8'h24, 32'h0200_0440);
		rc(8'h38, 32'h0000_e100);
		rc(8'h40, 32'h0000_0000);
		`CHK(e, 1'b1)
		$display("test reset values done");
		wr(8'h00, 32'h0000_0001);
		wr(8'h10, 32'h0000_0001);
		wr(8'h14, 32'h0000_0002);
		wr(8'h18, 32'h0000_0800);
		wr(8'h1c, 32'h0000_0100);
		wr(8'h20, 32'h0000_0200);
		cmd_in <= 12'hfff;
		cyc(5000);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[11:0] > 12'h000 && q[11:0] < 12'hfff, 1'b1)
		cyc(6000);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[11:0], 12'hfff)
		`CHK(q[27:16], shp(12'hfff, 12'h800, 12'h100, 12'h200))
		cmd_in <= 12'h100;
		cyc(10000);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[11:0] > 12'h100, 1'b1)
		cyc(10000);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[11:0], 12'h100)
		`CHK(q[27:16], 12'h000)
		cmd_in <= 12'h300;
		cyc(2000);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[27:16], shp(12'h300, 12'h800, 12'h100, 12'h200))
		$display("test ramp and shaping done");
		wr(8'h28, 32'h0000_1000);
		wr(8'h2c, 32'h0001_0010);
		pulse(n1);
		pulse(n2);
		`CHK(n1 + n2, 734)
		`CHK((n1 > n2) ? n1 - n2 : n2 - n1, 32)
		$display("test pwm done");
		wr(8'h24, 32'h0000_0000);
		wr(8'h00, 32'h0000_0004);
		cyc(10010);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[27:16], 12'h000)
		wr(8'h00, 32'h0000_000c);
		cyc(10010);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[27:16], shp(12'h300, 12'h800, 12'h100, 12'h200))
		wr(8'h00, 32'h0000_0001);
		$display("test pid done");
		wr(8'h34, 32'h0000_0400);
		wr(8'h0c, 32'h0000_0006);
		`CHK(ready_out, 1'b1)
		enable_pin <= 1'b0;
		cyc(8);
		`CHK(ready_out, 1'b0)
		`CHK(irq, 1'b1)
		rc(8'h04, 32'h0000_0014);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[11:0] < 12'h400, 1'b1)
		cyc(1000);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[11:0], 12'h400)
		rc(8'h08, 32'h0000_000d);
		wr(8'h08, 32'h0000_0004);
		`CHK(irq, 1'b0)
		wr(8'h00, 32'h0000_0011);
		rc(8'h18, 32'h0000_0fff);
		rc(8'h34, 32'h0000_0400);
		wr(8'h00, 32'h0000_0000);
		cyc(20);
		apb(1'b0, 8'h3c, 32'h0000_0000);
		`CHK(q[27:16], 12'h000)
		rc(8'h04, 32'h0000_0004);
		$display("test emergency done");
		enable_pin <= 1'b1;
		wr(8'h00, 32'h0000_0002);
		cyc(8);
		`CHK(ready_out, 1'b1)
		open_req <= 1'b1;
		cyc(8);
		`CHK(ready_out, 1'b0)
		`CHK(irq, 1'b1)
		rc(8'h04, 32'h0000_000e);
		wr(8'h08, 32'h0000_000f);
		`CHK(irq, 1'b0)
		open_req <= 1'b0;
		cyc(8);
		`CHK(ready_out, 1'b1)
		$display("test sensor done");
		end_sim;
	end
endmodule
bind pcc_top pcc_top_checker pcc_top_checker_i (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
	.sensor_open_pin(sensor_open_pin), .cmd_in(cmd_in), .fb_in(fb_in), .pwm_out(pwm_out),
	.ready_out(ready_out), .irq(irq));
